//--- verilog/efo_core.sv
module efo_core #(
    parameter longint RUN_OFF_CYCLES = efo_pkg::RUN_OFF_CYC,
    parameter longint CLEAN_CYCLES = efo_pkg::CLEAN_CYC,
    parameter logic [efo_pkg::RETRY_W-1:0] RETRY_MAX = efo_pkg::RETRY_DEF
) (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESET_N,
    // Option switches
    input wire logic OPT_HALL_LANTERN,
    input wire logic OPT_NO_RETURN_LATCH,
    input wire logic OPT_GRAY_PI,
    input wire logic OPT_ROPE_BRAKE,
    input wire logic OPT_DRIVE_COMPAT,
    input wire logic OPT_INT_STOP_BYPASS,
    input wire logic OPT_BLOWER,
    input wire logic OPT_BLOWER_INSP,
    input wire logic OPT_BLOWER_FIRE,
    input wire logic OPT_RESET_COUNTER,
    input wire logic OPT_NO_REDUNDANCY,
    input wire logic OPT_SAFE_INVERT,
    input wire logic OPT_FLASH_HALL_FIRE,
    input wire logic OPT_DOOR_SECURITY,
    input wire logic OPT_DOOR_CHECK,
    input wire logic OPT_ATTEND_DIR,
    input wire logic OPT_MEDICAL_KEY,
    input wire logic OPT_FIRE_MAIN_REAR,
    input wire logic OPT_FIRE_ALT_REAR,
    input wire logic OPT_IN_USE,
    input wire logic OPT_FREIGHT_CLOSE,
    input wire logic OPT_HALL_CLOSE,
    input wire logic OPT_TWO_FLOOR,
    input wire logic SINGLE_PUSH_BUTTON_CTRL,
    // Car and hoistway inputs
    input wire logic SLOWDOWN_IN,
    input wire logic STOPPED_DOORS_OPEN_IN,
    input wire logic FIRE_SW_OFF_IN,
    input wire logic FIRE_RETURN_REQ_IN,
    input wire logic [efo_pkg::POS_W-1:0] POSITION_IN,
    input wire logic DOOR_ZONE_IN,
    input wire logic DOORS_OPEN_IN,
    input wire logic DOORS_CLOSED_IN,
    input wire logic BRAKE_DROPPED_IN,
    input wire logic [efo_pkg::SPEED_W-1:0] SPEED_IN,
    input wire logic STOPPING_IN,
    input wire logic RUN_CMD_IN,
    input wire logic SHUTDOWN_DEFEAT_IN,
    input wire logic NORMAL_OP_IN,
    input wire logic FIRE_STOP_SW_IN,
    input wire logic FIRE_PHASE2_IN,
    input wire logic BLOWER_OVERLOAD_IN,
    input wire logic INSPECTION_IN,
    input wire logic AT_MAIN_IN,
    input wire logic DRIVE_FAULT_IN,
    input wire logic REDUNDANCY_ERR_IN,
    input wire logic SAFE_IN,
    input wire logic CAR_FIRE_FLASH_IN,
    input wire logic REOPEN_REQ_IN,
    input wire logic DOOR_CONTACTS_IN,
    input wire logic CALLS_UP_IN,
    input wire logic CALLS_DN_IN,
    input wire logic DIR_UP_IN,
    input wire logic DIR_DN_IN,
    input wire logic MED_RETURN_IN,
    input wire logic INDEPENDENT_IN,
    input wire logic MED_KEY_IN,
    input wire logic AT_FIRE_MAIN_IN,
    input wire logic AT_FIRE_ALT_IN,
    input wire logic SELECTIVE_REAR_IN,
    input wire logic MOVING_IN,
    input wire logic HALL_CALL_IN,
    input wire logic MULTI_FLOOR_RUN_IN,
    // Outputs
    output logic LANTERN_OUT,
    output logic FIRE_RETURN_OUT,
    output logic [efo_pkg::POS_W-1:0] PI_OUT,
    output logic ROPE_BRAKE_OUT,
    output logic FALSE_DOWN_LEVEL_OUT,
    output logic STOP_BYPASS_OUT,
    output logic BLOWER_RETURN_OUT,
    output logic SHUTDOWN_OUT,
    output logic REDUNDANCY_FAULT_OUT,
    output logic SAFE_FAULT_OUT,
    output logic HALL_FIRE_LIGHT_OUT,
    output logic DOOR_REOPEN_OUT,
    output logic DOOR_HOLD_OUT,
    output logic ATTEND_UP_OUT,
    output logic ATTEND_DN_OUT,
    output logic MED_LIGHT_OUT,
    output logic FIRE_REAR_DOOR_OUT,
    output logic IN_USE_OUT,
    output logic FREIGHT_CLOSE_OUT,
    output logic HALL_CLOSE_START_OUT,
    output logic FULL_SPEED_OUT
);
    import efo_pkg::*;

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    localparam int NSYNC = 12;
    // Reset to the idle level of each pin: blower ok, in door zone, brake dropped,
    // fire switch off, stop switch closed. Zeros would fake a hazard on power up.
    localparam logic [NSYNC-1:0] SYNC_IDLE = 12'h5C2;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] meta_ff;
    logic [NSYNC-1:0] sync_ff;
    // Safety related pins and the hall call; the rest arrive from scan logic
    assign raw_in = {SHUTDOWN_DEFEAT_IN, BLOWER_OVERLOAD_IN, SAFE_IN, DOOR_ZONE_IN, BRAKE_DROPPED_IN,
                     FIRE_SW_OFF_IN, DOOR_CONTACTS_IN, REOPEN_REQ_IN, DRIVE_FAULT_IN, RUN_CMD_IN,
                     FIRE_STOP_SW_IN, HALL_CALL_IN};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge MCLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    meta_ff[gi] <= SYNC_IDLE[gi];
                    sync_ff[gi] <= SYNC_IDLE[gi];
                end else begin
                    meta_ff[gi] <= raw_in[gi];
                    sync_ff[gi] <= meta_ff[gi];
                end
            end
        end
    endgenerate
    logic s_defeat, s_blower, s_safe, s_dz, s_brake, s_fire_off, s_contacts, s_reopen, s_dfault, s_run;
    logic s_stop_sw, s_hall;
    assign {s_defeat, s_blower, s_safe, s_dz, s_brake, s_fire_off, s_contacts, s_reopen, s_dfault, s_run,
            s_stop_sw, s_hall} = sync_ff;

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic defeat_d;
        logic below_slow;
        logic rb_trip;
        logic [CNT_W-1:0] off_cnt;
        logic [CNT_W-1:0] clean_cnt;
        logic [RETRY_W-1:0] retries;
        logic dfault_d;
        logic blower_ret;
        logic out_lantern;
        logic out_fire_ret;
        logic [POS_W-1:0] out_pi;
        logic out_fdl;
        logic out_bypass;
        logic out_shutdown;
        logic out_redund;
        logic out_safe_flt;
        logic out_hall_fire;
        logic out_reopen;
        logic out_hold;
        logic out_att_up;
        logic out_att_dn;
        logic out_med;
        logic out_rear;
        logic out_in_use;
        logic out_freight;
        logic out_hall_close;
        logic out_full;
    } efo_state_s;
    efo_state_s st_ff;
    efo_state_s nxt_st;
    logic fast;
    logic rb_event;
    assign fast = SPEED_IN > SLOW_FPM;

    // ************************************************************
    // Next state; every option is read live each cycle
    // ************************************************************
    always_comb begin
        nxt_st = st_ff;
        nxt_st.defeat_d = s_defeat;
        nxt_st.dfault_d = s_dfault;
        // Lantern at slowdown or after stop with doors open
        nxt_st.out_lantern = OPT_HALL_LANTERN ? SLOWDOWN_IN : STOPPED_DOORS_OPEN_IN;
        // Return latch, cancelled by the fire switch when allowed
        if (FIRE_RETURN_REQ_IN) begin
            nxt_st.out_fire_ret = 1'b1;
        end else if (OPT_NO_RETURN_LATCH && !s_fire_off && MOVING_IN) begin
            nxt_st.out_fire_ret = 1'b0;
        end else if (!MOVING_IN && !FIRE_RETURN_REQ_IN) begin
            nxt_st.out_fire_ret = 1'b0;
        end
        nxt_st.out_pi = OPT_GRAY_PI ? (POSITION_IN ^ (POSITION_IN >> 1)) : POSITION_IN;
        // Overspeed with run signals off, timed
        if (s_run || !fast) begin
            nxt_st.off_cnt = '0;
        end else if (st_ff.off_cnt < CNT_W'(RUN_OFF_CYCLES)) begin
            nxt_st.off_cnt = st_ff.off_cnt + CNT_W'(1);
        end
        // Slow crossing while stopping arms the re-acceleration check
        if (!STOPPING_IN) begin
            nxt_st.below_slow = 1'b0;
        end else if (!fast) begin
            nxt_st.below_slow = 1'b1;
        end
        // Trip wins over reset so a live hazard never clears
        if (s_defeat && !st_ff.defeat_d) begin
            nxt_st.rb_trip = 1'b0;
        end
        if (rb_event) begin
            nxt_st.rb_trip = 1'b1;
        end
        nxt_st.out_fdl = OPT_DRIVE_COMPAT && NORMAL_OP_IN;
        nxt_st.out_bypass = OPT_INT_STOP_BYPASS && FIRE_PHASE2_IN && !s_stop_sw;
        // Blower loss: return to main, then shut down
        if (OPT_BLOWER && !s_blower && !INSPECTION_IN && !FIRE_PHASE2_IN) begin
            nxt_st.blower_ret = 1'b1;
        end else if (s_blower) begin
            nxt_st.blower_ret = 1'b0;
        end
        // Drive retry budget, refilled after clean running
        if (s_dfault && !st_ff.dfault_d && OPT_RESET_COUNTER && st_ff.retries != RETRY_MAX) begin
            nxt_st.retries = st_ff.retries + RETRY_W'(1);
        end
        if (s_dfault) begin
            nxt_st.clean_cnt = '0;
        end else if (st_ff.clean_cnt >= CNT_W'(CLEAN_CYCLES) - CNT_W'(1)) begin
            nxt_st.clean_cnt = '0;
            nxt_st.retries = '0;
        end else if (MOVING_IN) begin
            nxt_st.clean_cnt = st_ff.clean_cnt + CNT_W'(1);
        end
        nxt_st.out_shutdown = (st_ff.blower_ret && AT_MAIN_IN)
            || (OPT_BLOWER && OPT_BLOWER_INSP && INSPECTION_IN && !s_blower)
            || (OPT_BLOWER && OPT_BLOWER_FIRE && FIRE_PHASE2_IN && !s_blower)
            || (OPT_RESET_COUNTER && st_ff.retries == RETRY_MAX && s_dfault);
        nxt_st.out_redund = REDUNDANCY_ERR_IN && !OPT_NO_REDUNDANCY;
        nxt_st.out_safe_flt = !MOVING_IN && (s_safe == OPT_SAFE_INVERT);
        nxt_st.out_hall_fire = OPT_FLASH_HALL_FIRE && CAR_FIRE_FLASH_IN;
        nxt_st.out_reopen = s_reopen && !(OPT_DOOR_SECURITY && SELECTIVE_REAR_IN && DOORS_CLOSED_IN);
        nxt_st.out_hold = OPT_DOOR_CHECK && s_contacts && DOORS_OPEN_IN;
        nxt_st.out_att_up = OPT_ATTEND_DIR ? DIR_UP_IN : CALLS_UP_IN;
        nxt_st.out_att_dn = OPT_ATTEND_DIR ? (DIR_DN_IN && !DIR_UP_IN) : CALLS_DN_IN;
        nxt_st.out_med = OPT_MEDICAL_KEY ? (INDEPENDENT_IN && MED_KEY_IN) : MED_RETURN_IN;
        nxt_st.out_rear = SELECTIVE_REAR_IN && ((OPT_FIRE_MAIN_REAR && AT_FIRE_MAIN_IN)
            || (OPT_FIRE_ALT_REAR && AT_FIRE_ALT_IN));
        nxt_st.out_in_use = SINGLE_PUSH_BUTTON_CTRL && OPT_IN_USE && (DOORS_OPEN_IN || MOVING_IN);
        nxt_st.out_freight = SINGLE_PUSH_BUTTON_CTRL && OPT_FREIGHT_CLOSE && DOORS_OPEN_IN;
        nxt_st.out_hall_close = SINGLE_PUSH_BUTTON_CTRL && OPT_HALL_CLOSE && s_hall && DOORS_OPEN_IN;
        nxt_st.out_full = MOVING_IN && (!OPT_TWO_FLOOR || MULTI_FLOOR_RUN_IN);
    end

    // Trip sources, gated by the option
    assign rb_event = OPT_ROPE_BRAKE && ((!s_dz && DOORS_OPEN_IN && MOVING_IN)
        || (!MOVING_IN && !s_run && !s_brake)
        || (st_ff.below_slow && STOPPING_IN && fast)
        || (st_ff.off_cnt >= CNT_W'(RUN_OFF_CYCLES)));

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge MCLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ************************************************************
    // Outputs straight from flops
    // ************************************************************
    assign LANTERN_OUT = st_ff.out_lantern;
    assign FIRE_RETURN_OUT = st_ff.out_fire_ret;
    assign PI_OUT = st_ff.out_pi;
    assign ROPE_BRAKE_OUT = st_ff.rb_trip;
    assign FALSE_DOWN_LEVEL_OUT = st_ff.out_fdl;
    assign STOP_BYPASS_OUT = st_ff.out_bypass;
    assign BLOWER_RETURN_OUT = st_ff.blower_ret;
    assign SHUTDOWN_OUT = st_ff.out_shutdown;
    assign REDUNDANCY_FAULT_OUT = st_ff.out_redund;
    assign SAFE_FAULT_OUT = st_ff.out_safe_flt;
    assign HALL_FIRE_LIGHT_OUT = st_ff.out_hall_fire;
    assign DOOR_REOPEN_OUT = st_ff.out_reopen;
    assign DOOR_HOLD_OUT = st_ff.out_hold;
    assign ATTEND_UP_OUT = st_ff.out_att_up;
    assign ATTEND_DN_OUT = st_ff.out_att_dn;
    assign MED_LIGHT_OUT = st_ff.out_med;
    assign FIRE_REAR_DOOR_OUT = st_ff.out_rear;
    assign IN_USE_OUT = st_ff.out_in_use;
    assign FREIGHT_CLOSE_OUT = st_ff.out_freight;
    assign HALL_CLOSE_START_OUT = st_ff.out_hall_close;
    assign FULL_SPEED_OUT = st_ff.out_full;

    // ************************************************************
    // Checks
    // ************************************************************
    a_rb_sticky: assert property (@(posedge MCLK) disable iff (!RESET_N)
        ROPE_BRAKE_OUT && !(s_defeat && !st_ff.defeat_d) |=> ROPE_BRAKE_OUT)
        else $error("rope brake cleared without defeat edge");
    a_rb_trip: assert property (@(posedge MCLK) disable iff (!RESET_N)
        rb_event |=> ROPE_BRAKE_OUT)
        else $error("rope brake missed trip");
    a_gray_pi: assert property (@(posedge MCLK) disable iff (!RESET_N)
        OPT_GRAY_PI |=> PI_OUT == ($past(POSITION_IN) ^ ($past(POSITION_IN) >> 1)))
        else $error("position indicator not gray");
    a_redund_mask: assert property (@(posedge MCLK) disable iff (!RESET_N)
        OPT_NO_REDUNDANCY |=> !REDUNDANCY_FAULT_OUT)
        else $error("redundancy fault while disabled");
    a_lantern_sel: assert property (@(posedge MCLK) disable iff (!RESET_N)
        OPT_HALL_LANTERN && SLOWDOWN_IN |=> LANTERN_OUT)
        else $error("lantern missing at slowdown");
    a_fdl_enable: assert property (@(posedge MCLK) disable iff (!RESET_N)
        FALSE_DOWN_LEVEL_OUT |-> $past(OPT_DRIVE_COMPAT))
        else $error("false down level without option");
    a_in_use: assert property (@(posedge MCLK) disable iff (!RESET_N)
        SINGLE_PUSH_BUTTON_CTRL && OPT_IN_USE && MOVING_IN |=> IN_USE_OUT)
        else $error("in use light off while moving");
    a_full_speed: assert property (@(posedge MCLK) disable iff (!RESET_N)
        OPT_TWO_FLOOR && !MULTI_FLOOR_RUN_IN |=> !FULL_SPEED_OUT)
        else $error("full speed on one floor run");
    a_door_sec: assert property (@(posedge MCLK) disable iff (!RESET_N)
        OPT_DOOR_SECURITY && SELECTIVE_REAR_IN && DOORS_CLOSED_IN |=> !DOOR_REOPEN_OUT)
        else $error("reopen while secured");
endmodule

//--- verilog/efo_pkg.sv
package efo_pkg;
    // ************************************************************
    // Timing
    // ************************************************************
    localparam int CLK_MHZ = 200;
    localparam int RUN_OFF_TIME_MS = 5000;
    localparam longint RUN_OFF_CYC = longint'(RUN_OFF_TIME_MS) * CLK_MHZ * 1000;
    localparam int CLEAN_TIME_MIN = 60;
    localparam longint CLEAN_CYC = longint'(CLEAN_TIME_MIN) * 60 * CLK_MHZ * 1000000;
    // ************************************************************
    // Widths and reset values
    // ************************************************************
    localparam int POS_W = 5;
    localparam int CNT_W = 40;
    localparam int RETRY_W = 4;
    localparam int SPEED_W = 12;
    localparam logic [SPEED_W-1:0] SLOW_FPM = 12'h032;
    localparam logic [RETRY_W-1:0] RETRY_DEF = 4'h3;
    localparam int FLASH_W = 24;
endpackage

//--- dv/efo_plant.sv
module efo_plant (
    // Clock
    input wire logic MCLK,
    // Commanded car speed
    input wire logic [efo_pkg::SPEED_W-1:0] spd_tgt,
    // Measured car speed
    output logic [efo_pkg::SPEED_W-1:0] SPEED_IN
);
    timeunit 1ns;
    timeprecision 100ps;
    import efo_pkg::*;
    // ************************************************************
    // Drive speed ramp
    // ************************************************************
    // Speed moves in steps, so every threshold crossing is really passed
    initial SPEED_IN = 12'h000;
    always @(posedge MCLK) begin
        if (SPEED_IN < spd_tgt) begin
            SPEED_IN <= SPEED_IN + 12'h008;
        end else if (SPEED_IN > spd_tgt) begin
            SPEED_IN <= SPEED_IN - 12'h008;
        end
    end
endmodule

//--- dv/efo_core_tb.sv
module efo_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import efo_pkg::*;
    typedef struct {int due; int idx; logic [4:0] val;} efo_note_s;
    // ************************************************************
    // Signals
    // ************************************************************
    logic MCLK = 1'h0, RESET_N = 1'h0, OPT_HALL_LANTERN = 1'h0, OPT_NO_RETURN_LATCH = 1'h0, OPT_GRAY_PI = 1'h0;
    logic OPT_ROPE_BRAKE = 1'h0, OPT_DRIVE_COMPAT = 1'h0, OPT_INT_STOP_BYPASS = 1'h0, OPT_BLOWER = 1'h0;
    logic OPT_BLOWER_INSP = 1'h0, OPT_BLOWER_FIRE = 1'h0, OPT_RESET_COUNTER = 1'h0, OPT_NO_REDUNDANCY = 1'h0;
    logic OPT_SAFE_INVERT = 1'h0, OPT_FLASH_HALL_FIRE = 1'h0, OPT_DOOR_SECURITY = 1'h0, OPT_DOOR_CHECK = 1'h0;
    logic OPT_ATTEND_DIR = 1'h0, OPT_MEDICAL_KEY = 1'h0, OPT_FIRE_MAIN_REAR = 1'h0, OPT_FIRE_ALT_REAR = 1'h0;
    logic OPT_IN_USE = 1'h0, OPT_FREIGHT_CLOSE = 1'h0, OPT_HALL_CLOSE = 1'h0, OPT_TWO_FLOOR = 1'h0;
    logic SINGLE_PUSH_BUTTON_CTRL = 1'h0, SLOWDOWN_IN = 1'h0, STOPPED_DOORS_OPEN_IN = 1'h0, FIRE_SW_OFF_IN = 1'h0;
    logic FIRE_RETURN_REQ_IN = 1'h0, DOOR_ZONE_IN = 1'h0, DOORS_OPEN_IN = 1'h0, DOORS_CLOSED_IN = 1'h0;
    logic BRAKE_DROPPED_IN = 1'h0, STOPPING_IN = 1'h0, RUN_CMD_IN = 1'h0, SHUTDOWN_DEFEAT_IN = 1'h0;
    logic NORMAL_OP_IN = 1'h0, FIRE_STOP_SW_IN = 1'h0, FIRE_PHASE2_IN = 1'h0, BLOWER_OVERLOAD_IN = 1'h0;
    logic INSPECTION_IN = 1'h0, AT_MAIN_IN = 1'h0, DRIVE_FAULT_IN = 1'h0, REDUNDANCY_ERR_IN = 1'h0, SAFE_IN = 1'h0;
    logic CAR_FIRE_FLASH_IN = 1'h0, REOPEN_REQ_IN = 1'h0, DOOR_CONTACTS_IN = 1'h0, CALLS_UP_IN = 1'h0;
    logic CALLS_DN_IN = 1'h0, DIR_UP_IN = 1'h0, DIR_DN_IN = 1'h0, MED_RETURN_IN = 1'h0, INDEPENDENT_IN = 1'h0;
    logic MED_KEY_IN = 1'h0, AT_FIRE_MAIN_IN = 1'h0, AT_FIRE_ALT_IN = 1'h0, SELECTIVE_REAR_IN = 1'h0;
    logic MOVING_IN = 1'h0, HALL_CALL_IN = 1'h0, MULTI_FLOOR_RUN_IN = 1'h0;
    logic [POS_W-1:0] POSITION_IN = 5'h00;
    logic [SPEED_W-1:0] SPEED_IN;
    logic [SPEED_W-1:0] spd_tgt = 12'h000;
    logic LANTERN_OUT, FIRE_RETURN_OUT, ROPE_BRAKE_OUT, FALSE_DOWN_LEVEL_OUT, STOP_BYPASS_OUT, BLOWER_RETURN_OUT;
    logic SHUTDOWN_OUT, REDUNDANCY_FAULT_OUT, SAFE_FAULT_OUT, HALL_FIRE_LIGHT_OUT, DOOR_REOPEN_OUT, DOOR_HOLD_OUT;
    logic ATTEND_UP_OUT, ATTEND_DN_OUT, MED_LIGHT_OUT, FIRE_REAR_DOOR_OUT, IN_USE_OUT, FREIGHT_CLOSE_OUT;
    logic HALL_CLOSE_START_OUT, FULL_SPEED_OUT;
    logic [POS_W-1:0] PI_OUT;
    logic [24:0] outs;
    logic [63:0] r;
    efo_note_s notes[$];
    efo_note_s n;
    int ncyc = 0, mismatches = 0, comparisons = 0, seed = 32'h571A3D7C;

    // Short counts keep the timed paths inside a short run
    efo_core #(.RUN_OFF_CYCLES(20), .CLEAN_CYCLES(50), .RETRY_MAX(4'h3)) dut_u (.*);
    efo_plant plant_u (.MCLK(MCLK), .spd_tgt(spd_tgt), .SPEED_IN(SPEED_IN));

    // All outputs in one vector, PI from bit 20
    assign outs = {PI_OUT, FULL_SPEED_OUT, HALL_CLOSE_START_OUT, FREIGHT_CLOSE_OUT, IN_USE_OUT, FIRE_REAR_DOOR_OUT,
        MED_LIGHT_OUT, ATTEND_DN_OUT, ATTEND_UP_OUT, DOOR_HOLD_OUT, DOOR_REOPEN_OUT, HALL_FIRE_LIGHT_OUT,
        SAFE_FAULT_OUT, REDUNDANCY_FAULT_OUT, SHUTDOWN_OUT, BLOWER_RETURN_OUT, STOP_BYPASS_OUT,
        FALSE_DOWN_LEVEL_OUT, ROPE_BRAKE_OUT, FIRE_RETURN_OUT, LANTERN_OUT};
    always #2.5 MCLK = ~MCLK;
    // ************************************************************
    // Checking
    // ************************************************************
    task automatic check(logic [4:0] seen, logic [4:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Note made at a driving edge, judged at the negedge after lat more edges
    task automatic note_exp(int idx, logic [4:0] val, int lat);
        notes.push_back('{ncyc + 1 + lat, idx, val});
    endtask
    // Monitor sampling at the settled half of the cycle
    always @(negedge MCLK) begin
        ncyc++;
        while (notes.size() > 0 && notes[0].due <= ncyc) begin
            n = notes.pop_front();
            check((n.idx == 20) ? outs[24:20] : {4'h0, outs[n.idx]}, n.val);
        end
    end
    task automatic step(int k);
        repeat (k) @(posedge MCLK);
    endtask
    task automatic rst();
        @(posedge MCLK);
        RESET_N <= 1'h0;
        step(2);
        RESET_N <= 1'h1;
        step(1);
    endtask
    // Bounded wait for an output to rise; running out ends the run
    task automatic wait_hi(int idx, int lim);
        int i;
        for (i = 0; i < lim && outs[idx] !== 1'h1; i++) @(negedge MCLK);
        check({4'h0, outs[idx]}, 5'h01);
        if (i == lim) test_done();
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        step(12);
        RESET_N <= 1'h1;
        step(1);
        // Random options and car state, held four edges so synced paths settle
        for (int k = 0; k < 300; k++) begin
            @(posedge MCLK);
            r = {$random(seed), $random(seed)};
            {OPT_HALL_LANTERN, SLOWDOWN_IN, STOPPED_DOORS_OPEN_IN, OPT_GRAY_PI, POSITION_IN, OPT_DRIVE_COMPAT,
                NORMAL_OP_IN, OPT_NO_REDUNDANCY, REDUNDANCY_ERR_IN, OPT_SAFE_INVERT, SAFE_IN, MOVING_IN,
                OPT_DOOR_SECURITY, SELECTIVE_REAR_IN, DOORS_CLOSED_IN, REOPEN_REQ_IN, OPT_DOOR_CHECK,
                DOOR_CONTACTS_IN, DOORS_OPEN_IN, OPT_ATTEND_DIR, CALLS_UP_IN, CALLS_DN_IN, DIR_UP_IN, DIR_DN_IN,
                OPT_MEDICAL_KEY, MED_RETURN_IN, INDEPENDENT_IN, MED_KEY_IN, OPT_FIRE_MAIN_REAR, OPT_FIRE_ALT_REAR,
                AT_FIRE_MAIN_IN, AT_FIRE_ALT_IN, SINGLE_PUSH_BUTTON_CTRL, OPT_IN_USE, OPT_FREIGHT_CLOSE,
                OPT_HALL_CLOSE, HALL_CALL_IN, OPT_TWO_FLOOR, MULTI_FLOOR_RUN_IN, OPT_INT_STOP_BYPASS,
                FIRE_STOP_SW_IN, OPT_FLASH_HALL_FIRE, CAR_FIRE_FLASH_IN, FIRE_PHASE2_IN} <= r[47:0];
            #1;
            note_exp(0, OPT_HALL_LANTERN ? SLOWDOWN_IN : STOPPED_DOORS_OPEN_IN, 3);
            note_exp(20, OPT_GRAY_PI ? POSITION_IN ^ (POSITION_IN >> 1) : POSITION_IN, 3);
            note_exp(3, OPT_DRIVE_COMPAT & NORMAL_OP_IN, 3);
            note_exp(4, OPT_INT_STOP_BYPASS & FIRE_PHASE2_IN & !FIRE_STOP_SW_IN, 3);
            note_exp(9, OPT_FLASH_HALL_FIRE & CAR_FIRE_FLASH_IN, 3);
            note_exp(7, !OPT_NO_REDUNDANCY & REDUNDANCY_ERR_IN, 3);
            note_exp(8, !MOVING_IN & (SAFE_IN == OPT_SAFE_INVERT), 3);
            note_exp(10, REOPEN_REQ_IN & !(OPT_DOOR_SECURITY & SELECTIVE_REAR_IN & DOORS_CLOSED_IN), 3);
            note_exp(11, OPT_DOOR_CHECK & DOOR_CONTACTS_IN & DOORS_OPEN_IN, 3);
            note_exp(12, OPT_ATTEND_DIR ? DIR_UP_IN : CALLS_UP_IN, 3);
            note_exp(13, OPT_ATTEND_DIR ? DIR_DN_IN & !DIR_UP_IN : CALLS_DN_IN, 3);
            note_exp(14, OPT_MEDICAL_KEY ? INDEPENDENT_IN & MED_KEY_IN : MED_RETURN_IN, 3);
            note_exp(15, SELECTIVE_REAR_IN & ((OPT_FIRE_MAIN_REAR & AT_FIRE_MAIN_IN) |
                (OPT_FIRE_ALT_REAR & AT_FIRE_ALT_IN)), 3);
            note_exp(16, SINGLE_PUSH_BUTTON_CTRL & OPT_IN_USE & (DOORS_OPEN_IN | MOVING_IN), 3);
            note_exp(17, SINGLE_PUSH_BUTTON_CTRL & OPT_FREIGHT_CLOSE & DOORS_OPEN_IN, 3);
            note_exp(18, SINGLE_PUSH_BUTTON_CTRL & OPT_HALL_CLOSE & HALL_CALL_IN & DOORS_OPEN_IN, 3);
            note_exp(19, MOVING_IN & (!OPT_TWO_FLOOR | MULTI_FLOOR_RUN_IN), 3);
            step(3);
        end
        $display("end of test option lamps");
        // Fire return cancelled by the car switch only when the latch is off
        for (int o = 0; o < 2; o++) begin
            rst();
            @(posedge MCLK);
            {FIRE_RETURN_REQ_IN, FIRE_SW_OFF_IN, MOVING_IN, FIRE_PHASE2_IN} <= 4'hE;
            OPT_NO_RETURN_LATCH <= o[0];
            step(4);
            FIRE_RETURN_REQ_IN <= 1'h0;
            step(2);
            FIRE_SW_OFF_IN <= 1'h0;
            note_exp(1, !o[0], 3);
            step(4);
            MOVING_IN <= 1'h0;
            step(3);
        end
        $display("end of test fire return");
        // Blower loss: inspection and phase two cases, then normal service
        for (int i = 0; i < 5; i++) begin
            rst();
            @(posedge MCLK);
            {OPT_BLOWER, BLOWER_OVERLOAD_IN, AT_MAIN_IN, INSPECTION_IN} <= {3'h6, i < 2};
            FIRE_PHASE2_IN <= (i == 2 || i == 3);
            {OPT_BLOWER_INSP, OPT_BLOWER_FIRE} <= {i[0], i[0]};
            step(4);
            BLOWER_OVERLOAD_IN <= 1'h0;
            note_exp(6, (i < 4) & i[0], 3);
            note_exp(5, i == 4, 3);
            step(4);
            AT_MAIN_IN <= 1'h1;
            note_exp(6, (i < 4) ? i[0] : 1'h1, 1);
            step(3);
        end
        $display("end of test blower");
        // Three faults shut down; a clean run in between restarts the count
        for (int c = 0; c < 2; c++) begin
            rst();
            @(posedge MCLK);
            {OPT_RESET_COUNTER, MOVING_IN, DRIVE_FAULT_IN} <= 3'h4;
            OPT_BLOWER <= 1'h0;
            repeat (2) begin
                step(1);
                DRIVE_FAULT_IN <= 1'h1;
                step(4);
                DRIVE_FAULT_IN <= 1'h0;
                note_exp(6, 5'h00, 3);
                step(4);
            end
            MOVING_IN <= c[0];
            step(70);
            MOVING_IN <= 1'h0;
            DRIVE_FAULT_IN <= 1'h1;
            note_exp(6, !c[0], 4);
            step(4);
        end
        $display("end of test retry count");
        // Rope brake: door zone, brake check, speed dip and run-off sources
        rst();
        @(posedge MCLK);
        {OPT_ROPE_BRAKE, DOORS_OPEN_IN, MOVING_IN, DOOR_ZONE_IN, BRAKE_DROPPED_IN, RUN_CMD_IN} <= 6'h1F;
        {SHUTDOWN_DEFEAT_IN, STOPPING_IN, FIRE_PHASE2_IN, INSPECTION_IN} <= 4'h0;
        spd_tgt <= 12'h000;
        step(5);
        // Option on at the same edge as the zone input drops, so only the zone exit can trip
        {OPT_ROPE_BRAKE, DOOR_ZONE_IN} <= 2'h2;
        note_exp(2, 5'h00, 1);
        note_exp(2, 5'h01, 3);
        step(5);
        {DOOR_ZONE_IN, SHUTDOWN_DEFEAT_IN} <= 2'h3;
        note_exp(2, 5'h00, 3);
        step(5);
        {MOVING_IN, RUN_CMD_IN, DOORS_OPEN_IN, BRAKE_DROPPED_IN} <= 4'h0;
        note_exp(2, 5'h01, 3);
        step(5);
        BRAKE_DROPPED_IN <= 1'h1;
        note_exp(2, 5'h01, 6);
        step(7);
        SHUTDOWN_DEFEAT_IN <= 1'h0;
        step(5);
        {SHUTDOWN_DEFEAT_IN, MOVING_IN, RUN_CMD_IN} <= 3'h7;
        note_exp(2, 5'h00, 3);
        spd_tgt <= 12'h060;
        step(20);
        {STOPPING_IN, SHUTDOWN_DEFEAT_IN} <= 2'h2;
        spd_tgt <= 12'h020;
        step(10);
        spd_tgt <= 12'h060;
        wait_hi(2, 40);
        @(posedge MCLK);
        STOPPING_IN <= 1'h0;
        step(5);
        SHUTDOWN_DEFEAT_IN <= 1'h1;
        note_exp(2, 5'h00, 3);
        step(5);
        RUN_CMD_IN <= 1'h0;
        note_exp(2, 5'h00, 10);
        step(11);
        wait_hi(2, 40);
        $display("end of test rope brake");
        step(4);
        test_done();
    end
endmodule
